// *** src/fms_pkg.sv ***
// constants, types and function list of the fused multiply-add unit
// Function
// [RQ1] multiplicand NaN: return it quietened
// [RQ2] multiplier NaN: return it quietened
// [RQ3] only addend NaN: return it quietened
// [RQ4] infinity meets infinity: sign agree or default NaN
// [RQ5] infinite product, finite addend: signed infinity
// [RQ6] infinity times zero: default NaN, invalid
// [RQ7] finite product, infinite addend: addend infinity
// [RQ8] zero plus zero: sign from signs, mode
// [RQ9] zero product sign from factor signs
// [RQ10] zero product: return addend or negated addend
// [RQ11] zero addend: product rounded once
// [RQ12] general case: exact sum, round once
// [RQ13] unmasked exception: destination kept, trap raised
// [RQ14] feature word bit 12 reports support
// [RQ15] software checks feature and state masks
// [RQ16] both 128-bit and 256-bit vector widths
// [RQ17] invalid operation sets sticky invalid flag
// [RQ18] cancelled zero negative only when rounding down
// [RQ19] quietening keeps quiet NaN, quietens signalling
// [RQ20] default NaN: sign one, top fraction one
package fms_pkg;
    // single precision layout
    localparam int          FRAC_W   = 23;
    localparam int          MANT_W   = FRAC_W + 1;
    localparam int          BIAS     = 127;
    localparam logic [7:0]  EXP_ONES = 8'hff;
    localparam logic [31:0] QNAN_BIT = 32'h0040_0000;
    localparam logic [31:0] DQNAN    = 32'hffc0_0000;
    localparam logic [30:0] INF_MAG  = 31'h7f80_0000;
    localparam logic [30:0] MAX_MAG  = 31'h7f7f_ffff;
    typedef struct packed {logic s; logic [7:0] e; logic [FRAC_W-1:0] f;} fms_fp_t;
    // exact sum frame and exponent arithmetic
    localparam int FRM_W = 3 * MANT_W + 3;
    localparam int PAD_P = FRM_W - 1 - 2 * MANT_W;
    localparam int PAD_Z = FRM_W - 1 - MANT_W;
    localparam int EW    = 13;
    localparam int SW    = 7;
    localparam logic signed [EW-1:0] LP_OFS = EW'(2 * (BIAS + FRAC_W));
    localparam logic signed [EW-1:0] LZ_OFS = EW'(BIAS + FRAC_W);
    localparam logic signed [EW-1:0] BE_OFS = EW'(FRM_W - 1 + BIAS);
    // operation form bits and rounding modes
    localparam int F_SUB = 0;
    localparam int F_NEG = 1;
    typedef enum logic [1:0] {RM_NEAR = 2'h0, RM_DOWN = 2'h1, RM_UP = 2'h2,
                              RM_ZERO = 2'h3} fms_rm_t;
    // exception flag positions
    localparam int FL_W  = 5;
    localparam int FL_IE = 0;
    localparam int FL_DE = 1;
    localparam int FL_OE = 2;
    localparam int FL_UE = 3;
    localparam int FL_PE = 4;
    // lanes: 8 singles in 256 bits, 4 in 128 bits
    localparam int LANES   = 8;
    localparam int LANES_N = 4;
    localparam int LW      = 3;
    // register map, byte addresses
    localparam int         AW      = 8;
    localparam int         BANK_SH = 5;
    localparam int         WORD_SH = 2;
    localparam logic [7:0] A_X     = 8'h00;
    localparam logic [7:0] A_Y     = 8'h20;
    localparam logic [7:0] A_Z     = 8'h40;
    localparam logic [7:0] A_CTRL  = 8'h60;
    localparam logic [7:0] A_STAT  = 8'h64;
    localparam logic [7:0] A_FEAT  = 8'h68;
    // control and status fields
    localparam int CT_START = 0;
    localparam int CT_FORM  = 1;
    localparam int CT_RM    = 3;
    localparam int CT_WIDE  = 5;
    localparam int CT_MASK  = 6;
    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_FLAGS = 3;
    localparam logic [FL_W-1:0] MASK_RST = 5'h1f;
    localparam int          FEAT_BIT  = 12;
    localparam logic [31:0] FEAT_WORD = 32'h0000_0001 << FEAT_BIT;
    // sequencer states
    typedef enum logic [2:0] {S_IDLE = 3'h1, S_RUN = 3'h2, S_COMMIT = 3'h4} fms_state_t;
endpackage : fms_pkg

// *** src/fms_lane_if.sv ***
// one lane of operands and result between sequencer and arithmetic core
`timescale 1ns/100ps
interface fms_lane_if;
    import fms_pkg::*;
    logic [31:0]     x;
    logic [31:0]     y;
    logic [31:0]     z;
    logic [1:0]      form;
    fms_rm_t         rm;
    logic [31:0]     res;
    logic [FL_W-1:0] flags;
    modport core (input x, y, z, form, rm, output res, flags);
    modport user (output x, y, z, form, rm, input res, flags);
endinterface : fms_lane_if

// *** src/fms_class.sv ***
// operand classifier for one single precision value
`timescale 1ns/100ps
module fms_class
    import fms_pkg::*;
(
    input  wire logic [31:0] op,
    output logic             nan,
    output logic             snan,
    output logic             inf,
    output logic             zero,
    output logic             den
);
    fms_fp_t f;
    // field tests
    assign f    = fms_fp_t'(op);
    assign nan  = (f.e == EXP_ONES) && (f.f != '0);
    assign snan = nan && !f.f[FRAC_W-1];
    assign inf  = (f.e == EXP_ONES) && (f.f == '0);
    assign zero = (f.e == '0) && (f.f == '0);
    assign den  = (f.e == '0) && (f.f != '0);
endmodule : fms_class

// *** src/fms_core.sv ***
// exact fused multiply-add of finite operands, rounded once
`timescale 1ns/100ps
module fms_core
    import fms_pkg::*;
(
    fms_lane_if.core lif
);
    fms_fp_t                 fx, fy, fz, rf;
    logic                    ps, zs, rs, use_p, g, sk, inc, tiny, ovf;
    logic [MANT_W-1:0]       m;
    logic [2*MANT_W-1:0]     mp;
    logic signed [EW-1:0]    fp, fq, d, be;
    logic [FRM_W-1:0]        pa, za, s, nrm;
    logic [SW-1:0]           nz;
    logic [30:0]             pk;

    function automatic logic signed [EW-1:0] uexp(input fms_fp_t f);
        return (f.e == '0) ? EW'(1) : EW'({1'b0, f.e});
    endfunction : uexp

    function automatic logic [SW-1:0] clamp(input logic signed [EW-1:0] v);
        return (v < 0 || v > FRM_W) ? SW'(FRM_W) : SW'(v);
    endfunction : clamp

    // right shift, lost bits folded into the lsb
    function automatic logic [FRM_W-1:0] shr(input logic [FRM_W-1:0] v, input logic [SW-1:0] n);
        return (v >> n) | FRM_W'(|(v & ~({FRM_W{1'b1}} << n)));
    endfunction : shr

    function automatic logic [SW-1:0] lzc(input logic [FRM_W-1:0] v);
        logic [SW-1:0] c;
        c = SW'(FRM_W);
        for (int i = 0; i < FRM_W; i++)
            if (v[i]) c = SW'(FRM_W - 1 - i);
        return c;
    endfunction : lzc

    // align, add, normalise, round
    always_comb
    begin
        fx = fms_fp_t'(lif.x);
        fy = fms_fp_t'(lif.y);
        fz = fms_fp_t'(lif.z);
        ps = fx.s ^ fy.s ^ lif.form[F_NEG];                 // RQ9
        zs = fz.s ^ lif.form[F_SUB];
        mp = {fx.e != '0, fx.f} * {fy.e != '0, fy.f};
        fp = uexp(fx) + uexp(fy) - LP_OFS - EW'(PAD_P);
        fq = uexp(fz) - LZ_OFS - EW'(PAD_Z);
        pa = {1'b0, mp, {PAD_P{1'b0}}};
        za = {1'b0, fz.e != '0, fz.f, {PAD_Z{1'b0}}};
        use_p = (za == '0) || ((mp != '0) && (fp >= fq));  // RQ10 RQ11
        d = use_p ? fp - fq : fq - fp;
        if (use_p) za = shr(za, clamp(d));
        else pa = shr(pa, clamp(d));
        if (ps == zs)
        begin
            s = pa + za;                                    // RQ12
            rs = ps;
        end
        else if (pa >= za)
        begin
            s = pa - za;
            rs = ps;
        end
        else
        begin
            s = za - pa;
            rs = zs;
        end
        if (s == '0) rs = (ps == zs) ? ps : (lif.rm == RM_DOWN); // RQ8 RQ18
        nz = lzc(s);
        nrm = s << nz;
        be = (use_p ? fp : fq) + BE_OFS - EW'(nz);
        tiny = be < EW'(1);
        if (tiny)
        begin
            nrm = shr(nrm, clamp(EW'(1) - be));
            be = '0;
        end
        m = nrm[FRM_W-1 -: MANT_W];
        g = nrm[FRM_W-1-MANT_W];
        sk = |nrm[FRM_W-2-MANT_W:0];
        unique case (lif.rm)
            RM_NEAR: inc = g & (sk | m[0]);
            RM_UP:   inc = !rs & (g | sk);
            RM_DOWN: inc = rs & (g | sk);
            RM_ZERO: inc = 1'b0;
        endcase
        if (be >= EW'({1'b0, EXP_ONES})) pk = INF_MAG;
        else pk = {be[7:0], m[FRAC_W-1:0]} + 31'(inc);     // RQ11 RQ12
        rf = {rs, pk};
        ovf = rf.e == EXP_ONES;
        if (ovf && !(lif.rm == RM_NEAR || (lif.rm == RM_UP && !rs)
                     || (lif.rm == RM_DOWN && rs)))
            rf = {rs, MAX_MAG};
        lif.res = rf;
        lif.flags = '0;
        lif.flags[FL_OE] = ovf;
        lif.flags[FL_UE] = tiny & (g | sk);
        lif.flags[FL_PE] = g | sk | ovf;
        if (s == '0) lif.res = {rs, 31'h0000_0000};
    end
endmodule : fms_core

// *** src/fms_top.sv ***
// fused multiply-add vector unit with special cases behind an ahb-lite slave
`timescale 1ns/100ps
module fms_top
    import fms_pkg::*;
(
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    fp_trap
);
    input  wire logic        hclk;
    input  wire logic        hresetn;
    input  wire logic        hsel;
    input  wire logic [31:0] haddr;
    input  wire logic [1:0]  htrans;
    input  wire logic        hwrite;
    input  wire logic [2:0]  hsize;
    input  wire logic [31:0] hwdata;
    input  wire logic        hready;
    output logic      [31:0] hrdata;
    output logic             hreadyout;
    output logic             hresp;
    output logic             fp_trap;

    // all state of the unit
    typedef struct packed {
        fms_state_t                st;
        logic [LW-1:0]             lane;
        logic                      wide;
        logic [1:0]                form;
        fms_rm_t                   rm;
        logic [FL_W-1:0]           mask;
        logic [FL_W-1:0]           flags;
        logic [FL_W-1:0]           acc;
        logic                      done;
        logic                      fault;
        logic                      trap;
        logic [LANES-1:0][31:0]    xv;
        logic [LANES-1:0][31:0]    yv;
        logic [LANES-1:0][31:0]    zv;
        logic [LANES-1:0][31:0]    tv;
        logic                      wr_pend;
        logic                      rd_pend;
        logic                      rd_ok;
        logic [AW-1:0]             addr;
        logic [31:0]               rdata;
    } fms_reg_t;

    fms_reg_t                st_r;
    fms_reg_t                st_nxt;
    fms_lane_if              lif ();
    logic [2:0][31:0]        ops;
    logic [2:0]              c_nan;
    logic [2:0]              c_snan;
    logic [2:0]              c_inf;
    logic [2:0]              c_zero;
    logic [2:0]              c_den;
    logic                    ps;
    logic                    zs;
    logic                    run;
    logic                    go;
    logic                    fin_f;
    logic [31:0]             lres;
    logic                    linv;
    logic [FL_W-1:0]         lflg;
    logic [LW-1:0]           last;

    // register read view
    function automatic logic [31:0] rd_mux(input fms_reg_t s);
        logic [31:0]         d;
        logic [LW-1:0]       i;
        d = '0;
        i = s.addr[BANK_SH-1:WORD_SH];
        if (s.addr[AW-1:BANK_SH] == A_X[AW-1:BANK_SH])
            d = s.xv[i];
        else if (s.addr[AW-1:BANK_SH] == A_Y[AW-1:BANK_SH])
            d = s.yv[i];
        else if (s.addr[AW-1:BANK_SH] == A_Z[AW-1:BANK_SH])
            d = s.zv[i];
        else if (s.addr == A_CTRL)
        begin
            d[CT_FORM +: 2] = s.form;
            d[CT_RM +: 2] = s.rm;
            d[CT_WIDE] = s.wide;
            d[CT_MASK +: FL_W] = s.mask;
        end
        else if (s.addr == A_STAT)
        begin
            d[ST_BUSY] = s.st != S_IDLE;
            d[ST_DONE] = s.done;
            d[ST_FAULT] = s.fault;
            d[ST_FLAGS +: FL_W] = s.flags;
        end
        else if (s.addr == A_FEAT)
            d = FEAT_WORD;                                   // RQ14
        return d;
    endfunction : rd_mux

    // current lane operands to classifiers and core
    assign ops[0] = st_r.xv[st_r.lane];
    assign ops[1] = st_r.yv[st_r.lane];
    assign ops[2] = st_r.zv[st_r.lane];
    assign lif.x = ops[0];
    assign lif.y = ops[1];
    assign lif.z = ops[2];
    assign lif.form = st_r.form;
    assign lif.rm = st_r.rm;

    // one classifier per operand
    for (genvar k = 0; k < 3; k++)
    begin : g_cls
        fms_class u_cls (
            .op   (ops[k]),
            .nan  (c_nan[k]),
            .snan (c_snan[k]),
            .inf  (c_inf[k]),
            .zero (c_zero[k]),
            .den  (c_den[k])
        );
    end

    fms_core u_core (
        .lif (lif.core)
    );

    // effective signs of product and addend
    assign ps = ops[0][31] ^ ops[1][31] ^ st_r.form[F_NEG];
    assign zs = ops[2][31] ^ st_r.form[F_SUB];
    assign run = st_r.st == S_RUN;
    assign fin_f = !(c_nan[0] | c_nan[1] | c_inf[0] | c_inf[1]);
    assign last = st_r.wide ? LW'(LANES - 1) : LW'(LANES_N - 1); // RQ16

    // special operand selection ahead of the core result
    always_comb
    begin
        lres = lif.res;
        linv = 1'b0;
        lflg = lif.flags;
        if (c_nan[0])
        begin
            lres = ops[0] | QNAN_BIT;                        // RQ1 RQ19
            linv = |c_snan;
            lflg = '0;
        end
        else if (c_nan[1])
        begin
            lres = ops[1] | QNAN_BIT;                        // RQ2
            linv = c_snan[1] | c_snan[2];
            lflg = '0;
        end
        else if (c_nan[2])
        begin
            lres = ops[2] | QNAN_BIT;                        // RQ3
            linv = c_snan[2];
            lflg = '0;
        end
        else if ((c_inf[0] & c_zero[1]) | (c_zero[0] & c_inf[1]))
        begin
            lres = DQNAN;                                    // RQ6 RQ20
            linv = 1'b1;
            lflg = '0;
        end
        else if (c_inf[0] | c_inf[1])
        begin
            lflg = '0;
            if (c_inf[2] && ps != zs)
            begin
                lres = DQNAN;                                // RQ4
                linv = 1'b1;                                 // RQ17
            end
            else
                lres = {ps, INF_MAG};                        // RQ4 RQ5
        end
        else if (c_inf[2])
        begin
            lres = {zs, INF_MAG};                            // RQ7
            lflg = '0;
        end
        else
            lflg[FL_DE] = |c_den;
    end

    // bus slave, register writes and lane sequencer
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.trap = 1'b0;
        go = 1'b0;
        // write data phase lands here
        if (st_r.wr_pend)
        begin
            st_nxt.wr_pend = 1'b0;
            if (st_r.st == S_IDLE)
            begin
                if (st_r.addr[AW-1:BANK_SH] == A_X[AW-1:BANK_SH])
                    st_nxt.xv[st_r.addr[BANK_SH-1:WORD_SH]] = hwdata;
                if (st_r.addr[AW-1:BANK_SH] == A_Y[AW-1:BANK_SH])
                    st_nxt.yv[st_r.addr[BANK_SH-1:WORD_SH]] = hwdata;
                if (st_r.addr[AW-1:BANK_SH] == A_Z[AW-1:BANK_SH])
                    st_nxt.zv[st_r.addr[BANK_SH-1:WORD_SH]] = hwdata;
                if (st_r.addr == A_CTRL)
                begin
                    st_nxt.form = hwdata[CT_FORM +: 2];
                    st_nxt.rm = fms_rm_t'(hwdata[CT_RM +: 2]);
                    st_nxt.wide = hwdata[CT_WIDE];
                    st_nxt.mask = hwdata[CT_MASK +: FL_W];
                    go = hwdata[CT_START];
                end
            end
            // write one to clear; hardware sets below win
            if (st_r.addr == A_STAT)
            begin
                st_nxt.done = st_r.done & ~hwdata[ST_DONE];
                st_nxt.fault = st_r.fault & ~hwdata[ST_FAULT];
                st_nxt.flags = st_r.flags & ~hwdata[ST_FLAGS +: FL_W];
            end
        end
        // reads take one wait state so data comes from a flop
        if (st_r.rd_pend)
        begin
            if (!st_r.rd_ok)
            begin
                st_nxt.rd_ok = 1'b1;
                st_nxt.rdata = rd_mux(st_r);
            end
            else
            begin
                st_nxt.rd_pend = 1'b0;
                st_nxt.rd_ok = 1'b0;
            end
        end
        // address phase
        if (hsel && htrans[1] && hready)
        begin
            st_nxt.addr = haddr[AW-1:0];
            st_nxt.wr_pend = hwrite;
            st_nxt.rd_pend = !hwrite;
            st_nxt.rd_ok = 1'b0;
        end
        // lane sequencer
        unique case (st_r.st)
            S_IDLE:
            begin
                if (go)
                begin
                    st_nxt.st = S_RUN;
                    st_nxt.lane = '0;
                    st_nxt.acc = '0;
                end
            end
            S_RUN:
            begin
                st_nxt.tv[st_r.lane] = lres;
                st_nxt.acc = st_r.acc | lflg | (FL_W'(linv) << FL_IE);
                if (st_r.lane == last)
                    st_nxt.st = S_COMMIT;
                else
                    st_nxt.lane = st_r.lane + LW'(1);
            end
            S_COMMIT:
            begin
                st_nxt.st = S_IDLE;
                st_nxt.done = 1'b1;
                st_nxt.flags = st_nxt.flags | st_r.acc;       // RQ17
                if (|(st_r.acc & ~st_r.mask))
                begin
                    st_nxt.fault = 1'b1;                      // RQ13
                    st_nxt.trap = 1'b1;
                end
                else
                begin
                    for (int i = 0; i < LANES; i++)
                        if (st_r.wide || i < LANES_N)
                            st_nxt.xv[i] = st_r.tv[i];
                end
            end
            default:
                st_nxt.st = S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
            st_r.st <= S_IDLE;
            st_r.rm <= RM_NEAR;
            st_r.mask <= MASK_RST;
        end
        else
            st_r <= st_nxt;
    end

    // bus outputs
    assign hrdata = st_r.rdata;
    assign hreadyout = !(st_r.rd_pend && !st_r.rd_ok);
    assign hresp = 1'b0;
    assign fp_trap = st_r.trap;

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_nan_x_first: assert property (run && c_nan[0]                       // RQ1
        |-> lres == (ops[0] | QNAN_BIT) && linv == |c_snan)
        else $error("multiplicand nan not returned quiet");

    a_nan_y_next: assert property (run && !c_nan[0] && c_nan[1]           // RQ2
        |-> lres == (ops[1] | QNAN_BIT) && linv == (c_snan[1] | c_snan[2]))
        else $error("multiplier nan not returned quiet");

    a_nan_z_only: assert property (run && !c_nan[0] && !c_nan[1] && c_nan[2] // RQ3
        |-> lres == (ops[2] | QNAN_BIT) && linv == c_snan[2])
        else $error("addend nan not returned quiet");

    a_inf_clash: assert property (run && !(|c_nan) && (c_inf[0] | c_inf[1]) // RQ4
        && !(c_zero[0] | c_zero[1]) && c_inf[2] && ps != zs
        |-> lres == DQNAN && linv)
        else $error("opposite infinities not invalid");

    a_inf_zero: assert property (run && !(|c_nan)                         // RQ6
        && ((c_inf[0] && c_zero[1]) || (c_zero[0] && c_inf[1]))
        |=> st_r.acc[FL_IE] && st_r.tv[$past(st_r.lane)] == DQNAN)
        else $error("inf times zero not default nan");

    a_addend_inf: assert property (run && !(|c_nan) && fin_f && c_inf[2]  // RQ7
        |-> lres == {zs, INF_MAG} && !linv)
        else $error("infinite addend sign wrong");

    a_zero_sign: assert property (run && !(|c_nan) && fin_f && c_zero[2]  // RQ18
        && (c_zero[0] || c_zero[1]) && ps != zs
        |-> lres == {st_r.rm == RM_DOWN, 31'h0000_0000})
        else $error("cancelled zero sign wrong");

    a_dest_kept: assert property (st_r.st == S_COMMIT                      // RQ13
        && |(st_r.acc & ~st_r.mask)
        |=> st_r.xv == $past(st_r.xv) && st_r.fault && fp_trap)
        else $error("destination changed on unmasked fault");

    a_narrow_run: assert property ($rose(run) && !st_r.wide                 // RQ16
        |-> ##4 st_r.st == S_COMMIT)
        else $error("narrow vector took wrong lane count");

    a_inv_sticky: assert property (st_r.st == S_COMMIT && st_r.acc[FL_IE]  // RQ17
        |=> st_r.flags[FL_IE] ##1 st_r.flags[FL_IE] || $past(st_r.wr_pend))
        else $error("invalid flag not set");

    a_feat_read: assert property (st_r.rd_pend && !st_r.rd_ok             // RQ14
        && st_r.addr == A_FEAT |=> hrdata[FEAT_BIT] && hreadyout)
        else $error("feature bit not reported");
endmodule : fms_top

// *** test/fms_host.sv ***
// ahb-lite master model standing in for the processor pipeline
`timescale 1ns/100ps
module fms_host
    import fms_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // bus idle at time zero
    initial
    begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    end

    // one single word transfer; address held until hready, data until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : xfer
endmodule : fms_host

// *** test/fms_top_tb.sv ***
// self-checking bench for the fused multiply-add unit
`timescale 1ns/100ps
module fms_top_tb
    import fms_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hreadyout, fp_trap, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_mismatch, cmp_count, cyc, traps;

    always #4 hclk = ~hclk;

    // cycle ceiling and trap pulse counter
    always @(posedge hclk)
    begin
        cyc++;
        if (fp_trap === 1'b1) traps++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    fms_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fp_trap(fp_trap));
    fms_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            n_mismatch++;
        end
    endtask : chk

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // operand classes
    function automatic logic isn(logic [31:0] v);
        return v[30:23] == EXP_ONES && v[22:0] != 0;
    endfunction : isn
    function automatic logic sn(logic [31:0] v);
        return isn(v) & ~v[22];
    endfunction : sn
    function automatic logic isi(logic [31:0] v);
        return v[30:0] == INF_MAG;
    endfunction : isi
    function automatic logic isz(logic [31:0] v);
        return v[30:0] == 31'h0;
    endfunction : isz

    // random zero, one, infinity or nan of either sign
    function automatic logic [31:0] rnd();
        logic [31:0] v;
        v = $urandom;
        case ($urandom % 5)
            0: v[30:0] = 31'h0;
            1: v[30:0] = 31'h3f80_0000;
            2: v[30:0] = INF_MAG;
            default: {v[30:23], v[0]} = {EXP_ONES, 1'b1};
        endcase
        return v;
    endfunction : rnd

    // expected {invalid, result}; finite operands are only zero or one, so exact
    function automatic logic [32:0] ref_fn(logic [31:0] x, y, z, logic [1:0] f, fms_rm_t rm);
        logic ps, zs, pz;
        ps = x[31] ^ y[31] ^ f[F_NEG];
        zs = z[31] ^ f[F_SUB];
        pz = isz(x) | isz(y);
        if (isn(x)) return {sn(x) | sn(y) | sn(z), x | QNAN_BIT};
        if (isn(y)) return {sn(y) | sn(z), y | QNAN_BIT};
        if (isn(z)) return {sn(z), z | QNAN_BIT};
        if (isi(x) & isz(y) | isz(x) & isi(y)) return {1'b1, DQNAN};
        if (isi(x) | isi(y)) return (isi(z) && ps != zs) ? {1'b1, DQNAN} : {1'b0, ps, INF_MAG};
        if (isi(z)) return {1'b0, zs, INF_MAG};
        if (pz == isz(z) && (pz || ps != zs))
            return {1'b0, (ps == zs) ? ps : (rm == RM_DOWN), 31'h0};
        if (pz) return {1'b0, zs, z[30:0]};
        if (isz(z)) return {1'b0, ps, 31'h3f80_0000};
        return {1'b0, ps, 31'h4000_0000};
    endfunction : ref_fn

    // one random batch: load lanes, start, wait, check status, trap and lanes
    task automatic run_batch();
        logic [31:0] x[8], y, z, q;
        logic [32:0] e[8];
        logic [1:0]  f;
        fms_rm_t     rm;
        logic [4:0]  mask;
        logic        wide, ie, fault;
        int          n, t0;
        f = 2'($urandom);
        rm = fms_rm_t'($urandom);
        wide = 1'($urandom);
        mask = ($urandom % 2) ? MASK_RST : 5'h1e;
        n = wide ? LANES : LANES_N;
        ie = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            x[i] = rnd();
            y = rnd();
            z = rnd();
            host.xfer(1'b1, A_X + 8'(4 * i), x[i], q);
            host.xfer(1'b1, A_Y + 8'(4 * i), y, q);
            host.xfer(1'b1, A_Z + 8'(4 * i), z, q);
            e[i] = ref_fn(x[i], y, z, f, rm);
            if (i < n) ie |= e[i][32];
        end
        fault = ie & ~mask[FL_IE];
        t0 = traps;
        host.xfer(1'b1, A_CTRL, {21'h0, mask, wide, rm, f, 1'b1}, q);
        do host.xfer(1'b0, A_STAT, 32'h0, q); while (q[ST_BUSY] !== 1'b0);
        chk("stat", {28'h0, ie, fault, 2'b10}, q);
        chk("trap", t0 + fault, traps);
        for (int i = 0; i < 8; i++)
        begin
            host.xfer(1'b0, A_X + 8'(4 * i), 32'h0, q);
            chk("lane", (i < n && !fault) ? e[i][31:0] : x[i], q);
        end
        host.xfer(1'b1, A_STAT, 32'hfe, q);
    endtask : run_batch

    // reset, identity and map checks, then random batches
    initial
    begin
        logic [31:0] q;
        void'($urandom(24));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        host.xfer(1'b0, A_FEAT, 32'h0, q);
        chk("feat", FEAT_WORD, q);
        host.xfer(1'b0, A_CTRL, 32'h0, q);
        chk("ctrl", {21'h0, MASK_RST, 6'h0}, q);
        host.xfer(1'b0, 8'hf0, 32'h0, q);
        chk("unmapped", 32'h0, q);
        chk("hresp", 32'h0, 32'(hresp));
        repeat (40) run_batch();
        print_verdict();
    end
endmodule : fms_top_tb
